// >>> core/rdc_reset_debug_ctrl.sv
// Purpose: Merge reset sources into one internal reset and steer the debug link.
// Assumes: reset_in is the cold (power-on) reset, synchronous and active high.
// Notes: The internal reset sets at once and clears through two flip-flops.

`timescale 1ns/1ps

module rdc_reset_debug_ctrl
   import rdc_pkg::*;
(
   // Clock and cold reset.
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Reset sources.
   input wire logic reset_pin_n_in,
   input wire logic watchdog_timeout_in,
   input wire logic sys_reset_request_in,
   // Core and security status.
   input wire logic core_halted_in,
   input wire logic flash_secure_set_in,
   // Debug pin configuration write from the port logic.
   input wire logic cfg_wr_in,
   input wire logic [2:0] cfg_data_in,
   // Internal reset and debug control.
   output logic sys_reset_out,
   output logic debug_accept_out,
   output logic watchdog_pause_out,
   output rdc_pins_t debug_pins_out,
   // Cold-only state.
   output rdc_cause_t reset_cause_flags_out,
   output logic flash_security_bit_out,
   output logic dbg_comp_clear_out
);

   logic reset_src;
   logic rst_meta;
   logic rst_sync;
   logic pin_meta;
   logic pin_sync;
   rdc_cfg_t debug_cfg;
   rdc_cfg_t next_debug_cfg;
   rdc_pins_t next_debug_pins;
   rdc_cause_t next_cause;
   logic next_fsb;
   logic next_accept;
   logic next_pause;

   // Any source raises the merged reset at once; the pin acts without the clock.
   assign reset_src = reset_in | ~reset_pin_n_in | watchdog_timeout_in
                      | sys_reset_request_in;

   // Release is delayed through two flip-flops so it meets the clock cleanly.
   always_ff @(posedge sys_clk_in or posedge reset_src) begin
      if (reset_src) begin
         rst_meta <= 1'b1;
         rst_sync <= 1'b1;
      end else begin
         rst_meta <= 1'b0;
         rst_sync <= rst_meta;
      end
   end

   assign sys_reset_out = rst_sync;

   // The pin level is brought into the clock domain before the debug gate and the pin cause flag use it.
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
      end else begin
         pin_meta <= reset_pin_n_in;
         pin_sync <= pin_meta;
      end
   end

   // Debug link gate and watchdog pause.
   always_comb begin
      next_accept = pin_sync;
      next_pause = core_halted_in;
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         debug_accept_out <= 1'b0;
         watchdog_pause_out <= 1'b0;
      end else begin
         debug_accept_out <= next_accept;
         watchdog_pause_out <= next_pause;
      end
   end

   // Configuration is loaded by the port logic; unknown codes disable debug.
   always_comb begin
      next_debug_cfg = debug_cfg;
      if (rst_sync) begin
         next_debug_cfg = RDC_CFG_RESET;
      end else if (cfg_wr_in) begin
         if (cfg_data_in > RDC_CFG_DISABLED) begin
            next_debug_cfg = RDC_CFG_DISABLED;
         end else begin
            next_debug_cfg = rdc_cfg_t'(cfg_data_in);
         end
      end
   end

   // Each configuration keeps a fixed set of pins on debug duty.
   always_comb begin
      unique case (debug_cfg)
         RDC_CFG_JTAG_SW: next_debug_pins = RDC_PINS_JTAG_SW;
         RDC_CFG_JTAG_SW_NOTRST: next_debug_pins = RDC_PINS_JTAG_SW_NOTRST;
         RDC_CFG_JTAG_TRACE: next_debug_pins = RDC_PINS_JTAG_TRACE;
         RDC_CFG_SW: next_debug_pins = RDC_PINS_SW;
         RDC_CFG_SW_SWV: next_debug_pins = RDC_PINS_SW_SWV;
         default: next_debug_pins = RDC_PINS_DISABLED;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         debug_cfg <= RDC_CFG_RESET;
         debug_pins_out <= RDC_PINS_JTAG_SW;
      end else begin
         debug_cfg <= next_debug_cfg;
         debug_pins_out <= next_debug_pins;
      end
   end

   // Cold-only state: warm resets never reach these flip-flops.
   always_comb begin
      next_cause = reset_cause_flags_out;
      next_cause.pin = reset_cause_flags_out.pin | ~pin_sync;
      next_cause.watchdog = reset_cause_flags_out.watchdog | watchdog_timeout_in;
      next_cause.sys_request = reset_cause_flags_out.sys_request | sys_reset_request_in;
      next_fsb = flash_security_bit_out | flash_secure_set_in;
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         reset_cause_flags_out <= RDC_CAUSE_RESET;
         flash_security_bit_out <= 1'b0;
         dbg_comp_clear_out <= 1'b1;
      end else begin
         reset_cause_flags_out <= next_cause;
         flash_security_bit_out <= next_fsb;
         dbg_comp_clear_out <= 1'b0;
      end
   end

   // Checks on the block's own behaviour.
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);

   sequence s_cfg_write_sw;
      cfg_wr_in && cfg_data_in == RDC_CFG_SW && !rst_sync && !reset_src;
   endsequence

   sequence s_quiet_cycle;
      !rst_sync && !cfg_wr_in;
   endsequence

   // Pin level held over three sampled edges, the depth of synchroniser plus gate.
   sequence s_pin_held_low;
      !reset_pin_n_in [*3];
   endsequence

   sequence s_pin_held_high;
      reset_pin_n_in [*3];
   endsequence

   chk_watchdog_reset: assert property (
      watchdog_timeout_in |=> sys_reset_out)
      else $error("Watchdog timeout did not reset the device.");

   chk_request_reset: assert property (
      sys_reset_request_in |=> sys_reset_out ##1 sys_reset_out)
      else $error("Software reset request did not hold the internal reset.");

   chk_release_sync: assert property (
      $fell(sys_reset_out) |-> !$past(reset_src) && !$past(reset_src, 2))
      else $error("Internal reset released without two quiet clocks.");

   chk_debug_refused: assert property (
      s_pin_held_low |=> !debug_accept_out)
      else $error("Debug link accepted during pin reset.");

   chk_watchdog_pause: assert property (
      core_halted_in |=> watchdog_pause_out)
      else $error("Watchdog not paused during core halt.");

   chk_cfg_after_reset: assert property (
      $fell(sys_reset_out) ##0 !cfg_wr_in |=> debug_pins_out == RDC_PINS_JTAG_SW)
      else $error("Debug pins not on debug duty after reset.");

   chk_pin_decode: assert property (
      s_cfg_write_sw ##1 s_quiet_cycle |=> debug_pins_out == RDC_PINS_SW)
      else $error("Serial-wire configuration drove the wrong pins.");

   chk_cause_sticky: assert property (
      reset_cause_flags_out.watchdog |=> reset_cause_flags_out.watchdog)
      else $error("Watchdog cause flag lost without cold reset.");

   chk_security_sticky: assert property (
      flash_security_bit_out && sys_reset_out |=> flash_security_bit_out)
      else $error("Security bit cleared by a warm reset.");

   chk_pause_released: assert property (
      !core_halted_in |=> !watchdog_pause_out)
      else $error("Watchdog still paused after the core left halt.");

   chk_pin_reset: assert property (
      !reset_pin_n_in |=> sys_reset_out)
      else $error("Pin reset did not reach the internal reset.");

   chk_accept_restored: assert property (
      s_pin_held_high |=> debug_accept_out)
      else $error("Debug link still refused after pin reset ended.");

endmodule

// >>> common/rdc_pkg.sv
// Purpose: Shared types and constants for the reset and debug control block.
// Assumes: One system clock at 200 MHz; debug pin configuration codes are local.
// Notes: Pin enable vectors list which debug pins keep their debug function.

package rdc_pkg;

   // System clock period in picoseconds.
   localparam int unsigned RDC_CLK_PERIOD_PS = 5000;

   // Least regulator settle time after power-up, held off by the outside party.
   localparam int unsigned RDC_REG_SETTLE_US = 700;
   localparam int unsigned RDC_REG_SETTLE_CYC =
      (RDC_REG_SETTLE_US * 1000000 + RDC_CLK_PERIOD_PS - 1) / RDC_CLK_PERIOD_PS;

   // Least warm reset pulse on the pin, in system clock periods.
   localparam int unsigned RDC_WARM_MIN_CYC = 12;

   // Debug pin configurations.
   typedef enum logic [2:0] {
      RDC_CFG_JTAG_SW        = 3'h0,
      RDC_CFG_JTAG_SW_NOTRST = 3'h1,
      RDC_CFG_JTAG_TRACE     = 3'h2,
      RDC_CFG_SW             = 3'h3,
      RDC_CFG_SW_SWV         = 3'h4,
      RDC_CFG_DISABLED       = 3'h5
   } rdc_cfg_t;

   // Debug function enable for each shared pin; a low bit frees the pin.
   typedef struct packed {
      logic trst;
      logic tdi;
      logic tdo_swv;
      logic tck;
      logic tms;
      logic trace_data;
      logic trace_clk;
   } rdc_pins_t;

   // Sticky record of which source caused a reset.
   typedef struct packed {
      logic pin;
      logic watchdog;
      logic sys_request;
   } rdc_cause_t;

   // Pin enable vectors, one per configuration.
   localparam rdc_pins_t RDC_PINS_JTAG_SW        = 7'h7C;
   localparam rdc_pins_t RDC_PINS_JTAG_SW_NOTRST = 7'h3C;
   localparam rdc_pins_t RDC_PINS_JTAG_TRACE     = 7'h7F;
   localparam rdc_pins_t RDC_PINS_SW             = 7'h06;
   localparam rdc_pins_t RDC_PINS_SW_SWV         = 7'h16;
   localparam rdc_pins_t RDC_PINS_DISABLED       = 7'h00;

   // Reset values.
   localparam rdc_cause_t RDC_CAUSE_RESET = 3'h0;
   localparam rdc_cfg_t RDC_CFG_RESET = RDC_CFG_JTAG_SW;

endpackage

// >>> verif/rdc_probe_model.sv
// Purpose: Reset supervisor and debug probe facing the reset block.
// Assumes: The pin changes at the falling clock edge.
// Notes: A warm pulse lasts WARM_CYC plus one clocks.
`timescale 1ns/1ps
module rdc_probe_model
   import rdc_pkg::*;
#(
   parameter int unsigned WARM_CYC = RDC_WARM_MIN_CYC
)(
   // Clock, supply state and warm request.
   input wire logic sys_clk_in,
   input wire logic power_good_in,
   input wire logic warm_req_in,
   // Link state from the device and the pin towards it.
   input wire logic debug_accept_in,
   output logic reset_pin_n_out,
   output logic link_up_out
);
   int unsigned cnt = 0;
   // Counts down the warm pulse.
   always @(negedge sys_clk_in) begin
      if (warm_req_in) cnt <= WARM_CYC;
      else if (cnt != 0) cnt <= cnt - 1;
   end
   // The pin stays low until power settles and through each warm pulse.
   assign reset_pin_n_out = power_good_in && (cnt == 0) && !warm_req_in;
   // The probe talks only after the pin reset is over.
   assign link_up_out = reset_pin_n_out && debug_accept_in;
endmodule

// >>> verif/reset_and_debug_control_test.sv
// Purpose: Self-checking bench for the reset and debug control block.
// Assumes: Inputs change at the falling edge; outputs are read there too.
// Notes: Expected results travel in a queue to the output monitor.
`timescale 1ns/1ps
module reset_and_debug_control_test;
   import rdc_pkg::*;
   typedef struct packed {logic [15:0] val; logic [15:0] mask;} rdc_note_t;
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic power_good = 1'b0;
   logic warm_req = 1'b0;
   logic watchdog_timeout_in = 1'b0;
   logic sys_reset_request_in = 1'b0;
   logic core_halted_in = 1'b0;
   logic flash_secure_set_in = 1'b0;
   logic cfg_wr_in = 1'b0;
   logic [2:0] cfg_data_in = 3'h0;
   logic reset_pin_n, link_up, sys_reset_out, debug_accept_out, watchdog_pause_out;
   logic flash_security_bit_out, dbg_comp_clear_out;
   rdc_pins_t debug_pins_out;
   rdc_cause_t reset_cause_flags_out;
   rdc_note_t notes[$];
   rdc_note_t note;
   logic [15:0] got;
   logic [2:0] code, fl;
   int num_errors = 0;
   int n_compared = 0;
   event sample_ev;

   // Free-running system clock.
   initial begin
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end

   rdc_reset_debug_ctrl dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .reset_pin_n_in(reset_pin_n), .watchdog_timeout_in(watchdog_timeout_in),
      .sys_reset_request_in(sys_reset_request_in), .core_halted_in(core_halted_in),
      .flash_secure_set_in(flash_secure_set_in), .cfg_wr_in(cfg_wr_in),
      .cfg_data_in(cfg_data_in), .sys_reset_out(sys_reset_out),
      .debug_accept_out(debug_accept_out), .watchdog_pause_out(watchdog_pause_out),
      .debug_pins_out(debug_pins_out), .reset_cause_flags_out(reset_cause_flags_out),
      .flash_security_bit_out(flash_security_bit_out),
      .dbg_comp_clear_out(dbg_comp_clear_out));
   rdc_probe_model partner (.sys_clk_in(sys_clk_in), .power_good_in(power_good),
      .warm_req_in(warm_req), .debug_accept_in(debug_accept_out),
      .reset_pin_n_out(reset_pin_n), .link_up_out(link_up));

   // Maps a configuration code to its pin enables.
   function automatic logic [6:0] pins_of(input logic [2:0] c);
      case (c)
         3'h0: pins_of = RDC_PINS_JTAG_SW;
         3'h1: pins_of = RDC_PINS_JTAG_SW_NOTRST;
         3'h2: pins_of = RDC_PINS_JTAG_TRACE;
         3'h3: pins_of = RDC_PINS_SW;
         3'h4: pins_of = RDC_PINS_SW_SWV;
         default: pins_of = RDC_PINS_DISABLED;
      endcase
   endfunction

   task automatic chk(input logic [15:0] val, input logic [15:0] mask);
      notes.push_back('{val, mask});
      -> sample_ev;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Writes a configuration and waits for its decode.
   task automatic cfg_write(input logic [2:0] c);
      cfg_data_in = c;
      cfg_wr_in = 1'b1;
      cyc(1);
      cfg_wr_in = 1'b0;
      cyc(1);
   endtask

   // Waits a bounded time for the merged reset to release.
   task automatic wait_idle();
      int n = 0;
      while (sys_reset_out !== 1'b0 && n < 20) begin
         cyc(1);
         n++;
      end
      if (sys_reset_out !== 1'b0) begin
         num_errors++;
         print_verdict();
      end
   endtask

   // Monitor: compares every pending note against the outputs.
   initial begin
      forever begin
         @(sample_ev);
         while (notes.size() > 0) begin
            note = notes.pop_front();
            got = {link_up, sys_reset_out, debug_accept_out, watchdog_pause_out,
               debug_pins_out, reset_cause_flags_out, flash_security_bit_out,
               dbg_comp_clear_out};
            n_compared++;
            if ((got & note.mask) !== (note.val & note.mask)) begin
               num_errors++;
               $display("unexpected at %0t got %h expected %h", $time,
                  got & note.mask, note.val & note.mask);
            end
         end
      end
   end

   // Cuts a hang short.
   initial begin
      #100000;
      num_errors++;
      print_verdict();
   end

   // Main sequence.
   initial begin
      void'($urandom(41));
      cyc(10);
      chk({4'h4, RDC_PINS_JTAG_SW, 5'h01}, 16'hffff);
      reset_in = 1'b0;
      power_good = 1'b1;
      wait_idle();
      cyc(4);
      chk({4'ha, RDC_PINS_JTAG_SW, 5'h00}, 16'hffff);
      $display("test cold reset done");
      for (int k = 0; k < 12; k++) begin
         code = (k < 8) ? k[2:0] : 3'($urandom_range(7));
         core_halted_in = 1'($urandom_range(1));
         cfg_write(code);
         chk({3'h0, core_halted_in, pins_of(code), 5'h00}, 16'h1fe0);
      end
      core_halted_in = 1'b0;
      $display("test configurations done");
      flash_secure_set_in = 1'b1;
      cyc(1);
      flash_secure_set_in = 1'b0;
      fl = 3'h0;
      for (int s = 0; s < 3; s++) begin
         cfg_write(3'h3);
         if (s == 0) watchdog_timeout_in = 1'b1;
         if (s == 1) sys_reset_request_in = 1'b1;
         // The probe counts on this same edge, so its request changes non-blocking.
         if (s == 2) warm_req <= 1'b1;
         #1;
         chk(16'h4000, 16'h4000);
         cyc(1);
         watchdog_timeout_in = 1'b0;
         sys_reset_request_in = 1'b0;
         warm_req <= 1'b0;
         cyc(3);
         if (s == 2) chk(16'h4000, 16'he000);
         cyc(12);
         wait_idle();
         cyc(4);
         fl = fl | ((s == 2) ? 3'h4 : (3'h2 >> s));
         chk({4'ha, RDC_PINS_JTAG_SW, fl, 2'b10}, 16'hffff);
      end
      $display("test reset sources done");
      reset_in = 1'b1;
      cyc(2);
      chk({4'h4, RDC_PINS_JTAG_SW, 5'h01}, 16'hffff);
      reset_in = 1'b0;
      cyc(10);
      chk({4'ha, RDC_PINS_JTAG_SW, 5'h00}, 16'hffff);
      $display("test second cold reset done");
      print_verdict();
   end
endmodule
